// ### rtl/lrs_pkg.sv
// Package of widths, field positions and carriers for the stream shim
package lrs_pkg;

	// --------------------------------------------------------------
	// Widths and field positions
	// --------------------------------------------------------------
	localparam int DATA_W    = 64;
	localparam int DW_W      = 32;
	localparam int KEEP_W    = DATA_W / 8;
	localparam int WIDE_W    = 128;
	localparam int USER_W    = 22;
	localparam int SOF_LO    = 10;
	localparam int SOF_HI    = 14;
	localparam int EOF_LO    = 17;
	localparam int EOF_HI    = 21;
	localparam int INFO_W    = 5;
	localparam int INFO_MARK = 4;
	localparam int INFO_3    = 3;
	localparam int INFO_2    = 2;
	localparam logic [KEEP_W-1:0] KEEP_ALL = 8'hFF;

	// --------------------------------------------------------------
	// Carriers
	// --------------------------------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [KEEP_W-1:0] keep;
		logic              last;
	} lrs_beat_s;

	typedef struct packed {
		logic [INFO_W-1:0] startInfo;
		logic [INFO_W-1:0] endInfo;
	} lrs_info_s;

	typedef enum logic [1:0] {
		LRS_OUT  = 2'h1,
		LRS_IN   = 2'h2
	} lrs_frame_e;

	// Swap dword positions, keeping byte order inside each dword
	function automatic logic [DATA_W-1:0] lrsSwap(
		input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] r;
		r = '0;
		for (int i = 0; i < DATA_W / DW_W; i++) begin
			r[i*DW_W +: DW_W] = d[(DATA_W/DW_W-1-i)*DW_W +: DW_W];
		end
		return r;
	endfunction : lrsSwap

	function automatic logic [WIDE_W-1:0] lrsSwapWide(
		input logic [WIDE_W-1:0] d);
		logic [WIDE_W-1:0] r;
		r = '0;
		for (int i = 0; i < WIDE_W / DW_W; i++) begin
			r[i*DW_W +: DW_W] = d[(WIDE_W/DW_W-1-i)*DW_W +: DW_W];
		end
		return r;
	endfunction : lrsSwapWide

endpackage : lrs_pkg

// ### rtl/lrs_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module lrs_skid_buf #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	import lrs_pkg::*;

	logic [WIDTH-1:0] slot0, slot1, next_slot0, next_slot1;
	logic [1:0]       count, next_count;
	logic             doPush, doPop;

	// --------------------------------------------------------------
	// Storage: slot0 is the head, output comes straight from a register
	// --------------------------------------------------------------
	assign inReady  = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign outData  = slot0;
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	// Next values of the two slots and fill count
	always_comb begin
		next_slot0 = slot0;
		next_slot1 = slot1;
		next_count = count;
		if (doPop) begin
			next_slot0 = slot1;
		end
		if (doPush) begin
			if (count == 2'h0 || (count == 2'h1 && doPop)) begin
				next_slot0 = inData;
			end else if (count == 2'h1 || doPop) begin
				next_slot1 = inData;
			end
		end
		next_count = count + {1'b0, doPush} - {1'b0, doPop};
	end

	// Register the slots
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			slot0 <= '0;
			slot1 <= '0;
			count <= 2'h0;
		end else begin
			slot0 <= next_slot0;
			slot1 <= next_slot1;
			count <= next_count;
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	buf_never_over_a: assert property (@(posedge clk_sys) disable iff (rst)
		count <= 2'h2)
		else $error("buffer count above two");
	buf_full_stalls_a: assert property (@(posedge clk_sys) disable iff (rst)
		(count == 2'h2 && !outReady) |=> $stable(outData) && outValid)
		else $error("held word changed while stalled");
	buf_fills_c: cover property (@(posedge clk_sys) disable iff (rst)
		count == 2'h2);

endmodule : lrs_skid_buf
`default_nettype wire

// ### rtl/lrs_stream_shim.sv
// Shim from the core stream ports to a legacy active-low frame interface
`timescale 1ns/100ps
`default_nettype none

module lrs_stream_shim (
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	// Core receive stream, narrow path
	input  wire lrs_pkg::lrs_beat_s        rxBeat,
	input  wire logic                      rxValid,
	output logic                           rxReady,
	// Core receive stream, wide path
	input  wire logic [lrs_pkg::WIDE_W-1:0] rxWideData,
	input  wire logic [lrs_pkg::USER_W-1:0] rxWideUser,
	input  wire logic                      rxWideLast,
	// Link state from the core
	input  wire logic                      linkUp,
	// Legacy receive side, narrow path
	output lrs_pkg::lrs_beat_s             legRxBeat,
	output logic                           legRxSrcRdy_n,
	input  wire logic                      legRxDstRdy_n,
	output logic                           legRxSof_n,
	output logic                           legRxEof_n,
	output logic                           legRxRem_n,
	output logic                           legRxDsc_n,
	// Legacy receive side, wide path
	output logic [lrs_pkg::WIDE_W-1:0]     legRxWideData,
	output logic                           legRxWideSof_n,
	output logic [1:0]                     legRxWideRem,
	output lrs_pkg::lrs_info_s             rxInfo,
	// Non-posted accept passes through
	input  wire logic                      legRxNpOk_n,
	output logic                           rx_nonposted_accept,
	// Legacy transmit side
	input  wire logic [lrs_pkg::DATA_W-1:0] legTxData,
	input  wire logic [lrs_pkg::KEEP_W-1:0] legTxKeep,
	input  wire logic                      legTxSof_n,
	input  wire logic                      legTxEof_n,
	input  wire logic                      legTxSrcRdy_n,
	output logic                           legTxDstRdy_n,
	input  wire logic [lrs_pkg::WIDE_W-1:0] legTxWideData,
	// Core transmit stream
	output lrs_pkg::lrs_beat_s             txBeat,
	output logic                           txValid,
	input  wire logic                      txReady,
	output logic [lrs_pkg::WIDE_W-1:0]     txWideData
);
	import lrs_pkg::*;

	// --------------------------------------------------------------
	// Receive buffer: a legacy stall loses no word
	// --------------------------------------------------------------
	lrs_beat_s bufOut;
	logic      bufValid, bufReady, rxAccept;
	logic      sofIn, sofOut;

	lrs_skid_buf #(.WIDTH($bits(lrs_beat_s) + 1)) u_rx_buf (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.inData   ({rxBeat, sofIn}),
		.inValid  (rxValid),
		.inReady  (rxReady),
		.outData  ({bufOut, sofOut}),
		.outValid (bufValid),
		.outReady (bufReady)
	);

	// --------------------------------------------------------------
	// Frame tracking on the core side
	// --------------------------------------------------------------
	lrs_frame_e frameState, next_frameState;

	assign rxAccept = rxValid && rxReady;

	always_comb begin
		next_frameState = frameState;
		if (rxAccept) begin
			next_frameState = rxBeat.last ? LRS_OUT : LRS_IN;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			frameState <= LRS_OUT;
		end else begin
			frameState <= next_frameState;
		end
	end

	// start marks the first valid beat
	assign sofIn = rxValid && (frameState != LRS_IN);

	// --------------------------------------------------------------
	// Legacy receive outputs, narrow path
	// --------------------------------------------------------------
	assign bufReady      = !legRxDstRdy_n;
	assign legRxSrcRdy_n = !bufValid;
	assign legRxBeat     = '{data: lrsSwap(bufOut.data), keep: bufOut.keep,
		last: bufOut.last};
	assign legRxSof_n    = !(bufValid && sofOut);
	assign legRxEof_n    = !(bufValid && bufOut.last);
	// remainder from keep; only meaningful at frame end
	assign legRxRem_n    = bufOut.last ? (bufOut.keep == KEEP_ALL) : 1'b1;

	// --------------------------------------------------------------
	// Discontinue
	// --------------------------------------------------------------
	logic next_dsc;

	// link loss is the only cause; frame still ends on last
	always_comb begin
		next_dsc = linkUp;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			legRxDsc_n <= 1'b1;
		end else begin
			legRxDsc_n <= next_dsc;
		end
	end

	// --------------------------------------------------------------
	// Wide receive path
	// --------------------------------------------------------------
	// sideband start and end info
	assign rxInfo = '{startInfo: rxWideUser[SOF_HI:SOF_LO],
		endInfo: rxWideUser[EOF_HI:EOF_LO]};
	assign legRxWideData  = lrsSwapWide(rxWideData);
	assign legRxWideSof_n = !rxInfo.startInfo[INFO_MARK];

	always_comb begin
		legRxWideRem[1] =
			(rxInfo.startInfo[INFO_MARK] && rxInfo.endInfo[INFO_MARK]
				&& rxInfo.endInfo[INFO_3])
			|| (!rxInfo.startInfo[INFO_MARK] && rxInfo.endInfo[INFO_MARK]
				&& rxInfo.endInfo[INFO_3])
			|| (rxInfo.startInfo[INFO_MARK] && !rxInfo.endInfo[INFO_MARK]
				&& !rxInfo.startInfo[INFO_3]);
		legRxWideRem[0] = !rxInfo.endInfo[INFO_2];
	end

	// polarity change only; timing is the user's duty
	assign rx_nonposted_accept = !legRxNpOk_n;

	// --------------------------------------------------------------
	// Transmit path
	// --------------------------------------------------------------
	// legacy transmit start is not used
	// keep from the user every cycle, valid or not; swap
	assign txBeat        = '{data: lrsSwap(legTxData), keep: legTxKeep,
		last: !legTxEof_n};
	assign txValid       = !legTxSrcRdy_n;
	assign legTxDstRdy_n = !txReady;
	// wide keep is the user's duty each cycle
	assign txWideData    = lrsSwapWide(legTxWideData);

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	frame_flag_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		rxAccept |=> (frameState == LRS_IN) == !$past(rxBeat.last))
		else $error("inside-frame flag did not load");
	start_mark_a: assert property (@(posedge clk_sys) disable iff (rst)
		(rxValid && frameState == LRS_IN) |-> !sofIn)
		else $error("start marked inside a frame");
	wide_start_a: assert property (@(posedge clk_sys) disable iff (rst)
		legRxWideSof_n == !rxWideUser[SOF_HI])
		else $error("wide start mismatch");
	rem_narrow_a: assert property (@(posedge clk_sys) disable iff (rst)
		(bufOut.last && bufOut.keep != KEEP_ALL) |-> !legRxRem_n)
		else $error("partial remainder not flagged");
	rem_full_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!bufOut.last || bufOut.keep == KEEP_ALL) |-> legRxRem_n)
		else $error("remainder low without partial end");
	rem_wide_a: assert property (@(posedge clk_sys) disable iff (rst)
		legRxWideRem[0] == !rxWideUser[EOF_LO + INFO_2])
		else $error("wide remainder bit zero wrong");
	dsc_delay_a: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(linkUp) |=> !legRxDsc_n)
		else $error("discontinue not one cycle after link loss");
	dsc_link_a: assert property (@(posedge clk_sys) disable iff (rst)
		legRxDsc_n == $past(linkUp))
		else $error("discontinue without link loss");
	swap_a: assert property (@(posedge clk_sys) disable iff (rst)
		legRxWideData[WIDE_W-1 -: DW_W] == rxWideData[DW_W-1:0])
		else $error("dword swap wrong");
	np_accept_a: assert property (@(posedge clk_sys) disable iff (rst)
		rx_nonposted_accept != legRxNpOk_n)
		else $error("non-posted accept polarity wrong");

	frame_two_c: cover property (@(posedge clk_sys) disable iff (rst)
		rxAccept && !rxBeat.last ##1 rxAccept && rxBeat.last);
	stall_c: cover property (@(posedge clk_sys) disable iff (rst)
		bufValid && legRxDstRdy_n ##1 bufValid && !legRxDstRdy_n);
	link_loss_c: cover property (@(posedge clk_sys) disable iff (rst)
		$fell(linkUp));
	rem_partial_c: cover property (@(posedge clk_sys) disable iff (rst)
		bufValid && bufOut.last && bufOut.keep != KEEP_ALL);

endmodule : lrs_stream_shim
`default_nettype wire

// ### testbench/lrs_core_model.sv
// Behavioural model of the core receive stream feeding the shim
`timescale 1ns/100ps
`default_nettype none
module lrs_core_model (
	input  wire logic              clk_sys,
	input  wire logic              rxReady,
	output var lrs_pkg::lrs_beat_s rxBeat,
	output logic                   rxValid,
	output logic                   rxWideLast
);
	import lrs_pkg::*;

	initial begin
		rxBeat = '0;
		rxValid = 1'b0;
		rxWideLast = 1'b0;
	end

	// Released beat shows inverted data so stale values never match
	task automatic idle;
		rxValid = 1'b0;
		rxBeat = ~rxBeat;
	endtask : idle

	task automatic send(input lrs_beat_s b, input int gap);
		int n;
		n = 0;
		if (gap > 0) begin
			idle();
			repeat (gap) begin
				@(posedge clk_sys);
				#1;
			end
		end
		rxBeat = b;
		rxValid = 1'b1;
		while (rxReady !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		@(posedge clk_sys);
		#1;
	endtask : send
endmodule : lrs_core_model
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the legacy stream shim
`timescale 1ns/100ps
`default_nettype none
module tb;
	import lrs_pkg::*;
	logic               clk_sys, rst, rxValid, rxReady, rxWideLast, linkUp;
	logic               legRxDstRdy_n, legRxSrcRdy_n, legRxSof_n, legRxEof_n;
	logic               legRxRem_n, legRxDsc_n, legRxWideSof_n, legRxNpOk_n;
	logic               rx_nonposted_accept, legTxSof_n, legTxEof_n;
	logic               legTxSrcRdy_n, legTxDstRdy_n, txValid, txReady;
	logic [127:0]       rxWideData, legRxWideData, legTxWideData, txWideData;
	logic [21:0]        rxWideUser;
	logic [1:0]         legRxWideRem;
	logic [63:0]        legTxData;
	logic [7:0]         legTxKeep;
	lrs_beat_s          rxBeat, legRxBeat, txBeat;
	lrs_info_s          rxInfo;
	int                 errors, check_count;

	lrs_stream_shim DUT (
		.clk_sys(clk_sys), .rst(rst), .rxBeat(rxBeat), .rxValid(rxValid),
		.rxReady(rxReady), .rxWideData(rxWideData), .rxWideUser(rxWideUser),
		.rxWideLast(rxWideLast), .linkUp(linkUp), .legRxBeat(legRxBeat),
		.legRxSrcRdy_n(legRxSrcRdy_n), .legRxDstRdy_n(legRxDstRdy_n),
		.legRxSof_n(legRxSof_n), .legRxEof_n(legRxEof_n),
		.legRxRem_n(legRxRem_n), .legRxDsc_n(legRxDsc_n),
		.legRxWideData(legRxWideData), .legRxWideSof_n(legRxWideSof_n),
		.legRxWideRem(legRxWideRem), .rxInfo(rxInfo),
		.legRxNpOk_n(legRxNpOk_n),
		.rx_nonposted_accept(rx_nonposted_accept),
		.legTxData(legTxData), .legTxKeep(legTxKeep),
		.legTxSof_n(legTxSof_n), .legTxEof_n(legTxEof_n),
		.legTxSrcRdy_n(legTxSrcRdy_n), .legTxDstRdy_n(legTxDstRdy_n),
		.legTxWideData(legTxWideData), .txBeat(txBeat), .txValid(txValid),
		.txReady(txReady), .txWideData(txWideData)
	);
	lrs_core_model core (.clk_sys(clk_sys), .rxReady(rxReady),
		.rxBeat(rxBeat), .rxValid(rxValid), .rxWideLast(rxWideLast));

	// Clock at 100 ns period
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic chkBit(input string what, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chkBit

	task automatic chkVec(input string what, input logic [127:0] e,
		input logic [127:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chkVec

	// Wait for a head word, check it, then pop it
	task automatic popChk(input logic [63:0] d, input logic s, input logic e,
		input logic r);
		int n;
		n = 0;
		while (legRxSrcRdy_n !== 1'b0 && n < 10) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chkVec("rx data", {64'h0, d}, {64'h0, legRxBeat.data});
		chkBit("rx sof", s, legRxSof_n);
		chkBit("rx eof", e, legRxEof_n);
		chkBit("rx rem", r, legRxRem_n);
		legRxDstRdy_n = 1'b0;
		@(posedge clk_sys);
		#1;
		legRxDstRdy_n = 1'b1;
	endtask : popChk

	// Two-beat frame fills the buffer, then a lone full frame
	task automatic tRxFrames;
		core.send('{64'h1111_2222_3333_4444, 8'hFF, 1'b0}, 0);
		core.send('{64'hAAAA_BBBB_CCCC_DDDD, 8'h0F, 1'b1}, 0);
		core.idle();
		chkBit("rx full", 1'b0, rxReady);
		popChk(64'h3333_4444_1111_2222, 1'b0, 1'b1, 1'b1);
		popChk(64'hCCCC_DDDD_AAAA_BBBB, 1'b1, 1'b0, 1'b0);
		chkBit("rx empty", 1'b1, legRxSrcRdy_n);
		core.send('{64'h5555_6666_7777_8888, 8'hFF, 1'b1}, 3);
		core.idle();
		popChk(64'h7777_8888_5555_6666, 1'b0, 1'b0, 1'b1);
	endtask : tRxFrames

	// Mid-run reset flushes the buffer and ends the open frame
	task automatic tReset;
		core.send('{64'h9999_0000_1111_AAAA, 8'hFF, 1'b0}, 0);
		core.idle();
		rst = 1'b1;
		#1;
		chkBit("reset flush", 1'b1, legRxSrcRdy_n);
		chkBit("reset ready2", 1'b1, rxReady);
		@(posedge clk_sys);
		#1;
		rst = 1'b0;
		core.send('{64'h4444_5555_6666_7777, 8'hFF, 1'b1}, 0);
		core.idle();
		popChk(64'h6666_7777_4444_5555, 1'b0, 1'b0, 1'b1);
	endtask : tReset

	// All start and end mark combinations on the wide path
	task automatic tWide;
		logic [21:0] u;
		for (int i = 0; i < 32; i++) begin
			@(posedge clk_sys);
			#1;
			u = '0;
			u[21:19] = {i[2], i[3], i[4]};
			u[17] = i[4];
			u[14:12] = {i[0], i[1], i[1]};
			u[10:9] = {i[2], i[3]};
			rxWideUser = u;
			rxWideData = {32'h0123_4567, 32'h89AB_CDEF, 32'h2222_0000, i};
			#1;
			chkBit("wide sof", ~u[14], legRxWideSof_n);
			chkBit("wide rem1", (u[14] & u[21] & u[20])
				| (~u[14] & u[21] & u[20]) | (u[14] & ~u[21] & ~u[13]),
				legRxWideRem[1]);
			chkBit("wide rem0", ~u[19], legRxWideRem[0]);
			chkVec("wide info", {118'h0, u[14:10], u[21:17]}, {118'h0, rxInfo});
			chkVec("wide data", {i, 32'h2222_0000, 32'h89AB_CDEF, 32'h0123_4567},
				legRxWideData);
		end
	endtask : tWide

	// Transmit pass-through with the start input toggled
	task automatic tTx;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			#1;
			legTxData = 64'h0123_4567_89AB_CDEF ^ {64{i[0]}};
			legTxWideData = {96'h0, legTxData[31:0]};
			// start input moves apart from the rest
			{legTxSof_n, legTxEof_n} = {i[1], i[0]};
			{legTxSrcRdy_n, txReady} = {2{i[0]}};
			legTxKeep = i[0] ? 8'hF0 : 8'h3F;
			#1;
			chkVec("tx data", {64'h0, legTxData[31:0], legTxData[63:32]},
				{64'h0, txBeat.data});
			chkVec("tx wide", {legTxData[31:0], 96'h0}, txWideData);
			chkVec("tx keep", {120'h0, legTxKeep}, {120'h0, txBeat.keep});
			chkBit("tx last", ~legTxEof_n, txBeat.last);
			chkBit("tx valid", ~legTxSrcRdy_n, txValid);
			chkBit("tx ready", ~txReady, legTxDstRdy_n);
		end
	endtask : tTx

	// Link loss shows one clock later; accept follows the legacy input
	task automatic tLink;
		@(posedge clk_sys);
		#1;
		linkUp = 1'b0;
		legRxNpOk_n = 1'b1;
		#1;
		chkBit("dsc early", 1'b1, legRxDsc_n);
		chkBit("np off", 1'b0, rx_nonposted_accept);
		@(posedge clk_sys);
		#1;
		chkBit("dsc late", 1'b0, legRxDsc_n);
		linkUp = 1'b1;
		legRxNpOk_n = 1'b0;
		@(posedge clk_sys);
		#1;
		chkBit("dsc back", 1'b1, legRxDsc_n);
		chkBit("np on", 1'b1, rx_nonposted_accept);
	endtask : tLink

	task automatic close_out;
		$display("Checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out

	// Watchdog well past the expected run length
	initial begin
		#500000;
		errors++;
		close_out();
	end

	// Main sequence
	initial begin
		{rst, linkUp, legRxDstRdy_n, legRxNpOk_n} = 4'hE;
		{legTxSof_n, legTxEof_n, legTxSrcRdy_n, txReady} = 4'hE;
		{rxWideData, rxWideUser, legTxData, legTxKeep} = '0;
		legTxWideData = '0;
		repeat (6) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		chkBit("reset ready", 1'b1, rxReady);
		tRxFrames();
		tReset();
		tWide();
		tTx();
		tLink();
		close_out();
	end
endmodule : tb
`default_nettype wire
